// ==== dv/pwmc_load.sv ====
// Load on the waveform pin: pull-down, high-time and edge counters
`timescale 1ns/100ps
module pwmc_load (
	input  wire logic        clk_i,
	input  wire logic        clr_i,
	input  wire logic        pin_i,
	input  wire logic        pin_en_i,
	output logic      [15:0] hi_cnt_o,
	output logic      [15:0] edge_cnt_o
);
	logic lvl;
	logic lvl_q;
	// Pull-down wins once the pin lets go of the line
	assign lvl = pin_en_i & pin_i;
	always_ff @(posedge clk_i) begin
		lvl_q <= lvl;
		hi_cnt_o <= clr_i ? 16'h0000 : hi_cnt_o + 16'(lvl);
		edge_cnt_o <= clr_i ? 16'h0000 : edge_cnt_o + 16'(lvl != lvl_q);
	end
endmodule

// ==== dv/pwmc_sva.sv ====
// Port-level checks for the PWM channel block
`timescale 1ns/100ps
`include "pwmc_defs.svh"
module pwmc_sva
	import pwmc_pkg::*;
(
	input wire logic                    sys_clk_i,
	input wire logic                    rst_n_i,
	input wire logic                    psel_i,
	input wire logic                    penable_i,
	input wire logic                    pwrite_i,
	input wire logic [`PWMC_ADDR_W-1:0] paddr_i,
	input wire logic [31:0]             pwdata_i,
	input wire logic [31:0]             prdata_o,
	input wire logic                    pready_o,
	input wire logic                    pslverr_o,
	input wire logic                    offset_match_event_o,
	input wire logic                    reload_done_trigger_o,
	input wire logic                    pwm_pin_o,
	input wire logic                    pwm_pin_en_o,
	input wire logic                    irq_o
);
	logic       acc;
	logic [5:0] con;
	logic [3:0] ie;
	assign acc = psel_i & penable_i;
	// Shadows of software-owned bits, so outputs can be tied to them
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i)
			con <= 6'h00;
		else if (acc && pwrite_i && paddr_i == `PWMC_OFS_CON)
			con <= {pwdata_i[7:6], pwdata_i[4:2], 1'b0};
	end
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i)
			ie <= 4'h0;
		else if (acc && pwrite_i && paddr_i == `PWMC_OFS_INTE)
			ie <= pwdata_i[3:0];
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	chk_zero_wait: assert property (acc |-> pready_o)
		else $error("ready missing in access phase");
	chk_bad_addr: assert property (acc && paddr_i > 8'h3C |-> pslverr_o)
		else $error("unmapped access not refused");
	chk_idle_bus: assert property (!acc |-> prdata_o == 32'h0 && !pslverr_o)
		else $error("read data or error outside access");
	chk_con_read: assert property (acc && !pwrite_i && paddr_i == 8'h00
		|-> prdata_o[31:6] == {24'h0, con[5:4]} && prdata_o[4:0] == con[3:0] << 1)
		else $error("control readback wrong");
	chk_pin_gated: assert property ($past(rst_n_i) && !$past(con[4]) |-> !pwm_pin_o)
		else $error("pin driven while output disconnected");
	chk_pin_enable: assert property ($past(rst_n_i) |-> pwm_pin_en_o == $past(con[4]))
		else $error("pin enable does not follow control");
	chk_irq_mask: assert property (ie == 4'h0 |-> !irq_o)
		else $error("interrupt with all enables clear");
	chk_irq_off: assert property (!con[5] && !$past(con[5]) |-> !irq_o)
		else $error("interrupt while channel disabled");
	chk_ofs_pulse: assert property (offset_match_event_o |=> !offset_match_event_o)
		else $error("offset event longer than a cycle");
	chk_load_pulse: assert property (reload_done_trigger_o |=> !reload_done_trigger_o)
		else $error("reload event longer than a cycle");
	cov_irq: cover property (irq_o);
	cov_load: cover property (reload_done_trigger_o);
	cov_err: cover property (acc && pslverr_o);
	cov_ofs: cover property (offset_match_event_o);
endmodule

bind pwmc_top pwmc_sva u_sva (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
	.offset_match_event_o(offset_match_event_o), .pwm_pin_o(pwm_pin_o),
	.reload_done_trigger_o(reload_done_trigger_o),
	.pwm_pin_en_o(pwm_pin_en_o));

// ==== dv/test_pwmc_top.sv ====
// Self-checking bench for the PWM channel block
`timescale 1ns/100ps
module test_pwmc_top
	import pwmc_pkg::*;
;
	localparam int PER = 10;
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0;
	logic        pwr = 1'b0, sleep = 1'b0, ftk = 1'b0, stk = 1'b0;
	logic        clr = 1'b0, pready, pslverr, ofs_ev, ld_ev, pin, pin_en, irq;
	logic [7:0]  paddr = 8'h00, rq, ph, dc;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0]  peer_off = 4'h0, peer_ld = 4'h0;
	logic [15:0] hi, ed, prev;
	logic        re;
	int          errors = 0, n_tests = 0, i, seed, n_ld = 0;
	logic [7:0]  addr [9] = '{8'h04, 8'h0C, 8'h14, 8'h18, 8'h1C, 8'h20,
		8'h24, 8'h28, 8'h2C};
	logic [7:0]  mask [9] = '{8'h0F, 8'h73, 8'h73, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF};
	logic [2:0]  psl [2] = '{3'd1, 3'd7};

	pwmc_top u_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.sleep_i(sleep), .fast_osc_tick_i(ftk), .slow_osc_tick_i(stk),
		.peer_offset_match_i(peer_off), .peer_reload_done_i(peer_ld),
		.offset_match_event_o(ofs_ev), .reload_done_trigger_o(ld_ev),
		.pwm_pin_o(pin), .pwm_pin_en_o(pin_en), .irq_o(irq));
	pwmc_load u_load (.clk_i(clk), .clr_i(clr), .pin_i(pin),
		.pin_en_i(pin_en), .hi_cnt_o(hi), .edge_cnt_o(ed));

	always #10 clk = ~clk;
	// Every buffer load gives one pulse on the reload event output
	always @(posedge clk) begin
		if (ld_ev === 1'b1)
			n_ld++;
	end
	// Fast oscillator at half the system rate; offset pulses are ignored
	// in independent run, so they are random noise here
	always @(posedge clk) begin
		ftk <= ~ftk;
		stk <= 1'($random(seed));
		peer_off <= 4'($random(seed)) & 4'hE;
	end

	task stop_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task cmp_reg(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t register %h expected %h", $time, got, exp);
		end
	endtask

	task cmp_cnt(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t count %0d expected %0d", $time, got, exp);
		end
	endtask

	task apb(input logic [7:0] a, input logic w, input logic [7:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		rq = prdata[7:0];
		re = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (k >= 16) begin
			errors++;
			$display("FAIL %0t bus answer timed out", $time);
			stop_test();
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(a, 1'b1, d);
	endtask

	task rd(input logic [7:0] a);
		apb(a, 1'b0, 8'h00);
	endtask

	task meas(input int n);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (n) @(posedge clk);
		#1;
	endtask

	function logic [15:0] exp_hi(input logic [7:0] p, input logic [7:0] d);
		return 16'(PER * (d - p));
	endfunction

	function logic [15:0] exp_mode(input int m, input logic [7:0] d);
		if (m == 1)
			return 16'd200;
		if (m == 2)
			return 16'd100;
		return 16'(20 * d);
	endfunction

	initial begin
		seed = 32'hfaaa;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 6; i++) begin
			rd(8'(i * 4));
			cmp_reg(rq, 8'h00);
		end
		for (i = 0; i < 9; i++) begin
			dc = 8'($random(seed));
			wr(addr[i], dc);
			rd(addr[i]);
			cmp_reg(rq, dc & mask[i]);
		end
		wr(8'h40, 8'hFF);
		rd(8'h40);
		cmp_reg({re, rq[6:0]}, 8'h80);
		wr(8'h00, 8'h2C);
		rd(8'h00);
		cmp_reg(rq, 8'h0C);
		$display("register access test done");
		wr(8'h0C, 8'h00);
		wr(8'h14, 8'h00);
		wr(8'h28, 8'h00);
		wr(8'h2C, 8'(PER - 1));
		wr(8'h18, 8'h00);
		wr(8'h20, 8'h00);
		wr(8'h1C, 8'h02);
		wr(8'h24, 8'h06);
		wr(8'h10, 8'h80);
		wr(8'h04, 8'h0F);
		rd(8'h10);
		cmp_reg(rq, 8'h00);
		wr(8'h00, 8'hC0);
		prev = exp_hi(8'h02, 8'h06);
		for (i = 0; i < 3; i++) begin
			ph = 8'($unsigned($random(seed)) % 4);
			dc = ph + 8'd1 + 8'($unsigned($random(seed)) % 5);
			wr(8'h1C, ph);
			wr(8'h24, dc);
			meas(100);
			cmp_cnt(hi, prev);
			wr(8'h10, 8'h80);
			repeat (30) @(posedge clk);
			meas(100);
			prev = exp_hi(ph, dc);
			cmp_cnt(hi, prev);
			rd(8'h10);
			cmp_reg(rq, 8'h00);
		end
		rd(8'h08);
		cmp_reg(rq & 8'h07, 8'h07);
		cmp_reg({7'h00, irq}, 8'h01);
		wr(8'h04, 8'h00);
		#1;
		cmp_reg({7'h00, irq}, 8'h00);
		wr(8'h00, 8'hD0);
		meas(100);
		cmp_cnt(hi, 16'd100 - prev);
		wr(8'h00, 8'hC0);
		$display("waveform and reload test done");
		foreach (psl[j]) begin
			wr(8'h0C, {1'b0, psl[j], 4'h0});
			repeat (20 << psl[j]) @(posedge clk);
			meas(100 << psl[j]);
			cmp_cnt(hi, prev << psl[j]);
		end
		wr(8'h0C, 8'h01);
		sleep <= 1'b1;
		repeat (20) @(posedge clk);
		meas(200);
		cmp_cnt(hi, prev << 1);
		wr(8'h0C, 8'h00);
		meas(50);
		cmp_cnt(ed, 16'd0);
		sleep <= 1'b0;
		wr(8'h0C, 8'h03);
		meas(50);
		cmp_cnt(ed, 16'd0);
		wr(8'h0C, 8'h00);
		$display("clock test done");
		for (i = 1; i < 4; i++) begin
			wr(8'h00, 8'hC0 | 8'(i << 2));
			repeat (40) @(posedge clk);
			meas(200);
			cmp_cnt(hi, exp_mode(i, dc));
		end
		wr(8'h00, 8'hC0);
		wr(8'h1C, 8'h01);
		wr(8'h24, 8'h08);
		wr(8'h10, 8'hC2);
		repeat (30) @(posedge clk);
		meas(100);
		cmp_cnt(hi, prev);
		peer_ld <= 4'h4;
		@(posedge clk);
		peer_ld <= 4'h0;
		repeat (30) @(posedge clk);
		meas(100);
		cmp_cnt(hi, exp_hi(8'h01, 8'h08));
		rd(8'h10);
		cmp_reg(rq, 8'h42);
		wr(8'h00, 8'h40);
		repeat (3) @(posedge clk);
		rd(8'h08);
		cmp_reg(rq, 8'h00);
		cmp_cnt(16'(n_ld), 16'd5);
		$display("trigger and disable test done");
		stop_test();
	end

	initial begin
		repeat (95000) @(posedge clk);
		errors++;
		$display("FAIL %0t run did not finish", $time);
		stop_test();
	end
endmodule

// ==== src/pwmc_defs.svh ====
// Register offsets, field positions, reset values and prescale limit
`ifndef PWMC_DEFS_SVH
`define PWMC_DEFS_SVH

`define PWMC_ADDR_W          8
`define PWMC_OFS_CON         8'h00
`define PWMC_OFS_INTE        8'h04
`define PWMC_OFS_INTF        8'h08
`define PWMC_OFS_CLKCON      8'h0C
`define PWMC_OFS_LDCON       8'h10
`define PWMC_OFS_OFCON       8'h14
`define PWMC_OFS_PHH         8'h18
`define PWMC_OFS_PHL         8'h1C
`define PWMC_OFS_DCH         8'h20
`define PWMC_OFS_DCL         8'h24
`define PWMC_OFS_PRH         8'h28
`define PWMC_OFS_PRL         8'h2C
`define PWMC_OFS_OFH         8'h30
`define PWMC_OFS_OFL         8'h34
`define PWMC_OFS_TMRH        8'h38
`define PWMC_OFS_TMRL        8'h3C

// channel_control
`define PWMC_CON_EN          7
`define PWMC_CON_OE          6
`define PWMC_CON_OUT         5
`define PWMC_CON_POL         4
`define PWMC_CON_MODE_HI     3
`define PWMC_CON_MODE_LO     2
// clock_select
`define PWMC_CLK_PS_HI       6
`define PWMC_CLK_PS_LO       4
`define PWMC_CLK_CS_HI       1
`define PWMC_CLK_CS_LO       0
// reload_control
`define PWMC_LD_ARMED        7
`define PWMC_LD_TRIG         6
`define PWMC_LD_SRC_HI       1
`define PWMC_LD_SRC_LO       0
// slave_sync_control
`define PWMC_OF_STYLE_HI     6
`define PWMC_OF_STYLE_LO     5
`define PWMC_OF_DIR          4
`define PWMC_OF_SRC_HI       1
`define PWMC_OF_SRC_LO       0
// Flag and enable bit positions
`define PWMC_IRQ_OFFSET      3
`define PWMC_IRQ_ANGLE       2
`define PWMC_IRQ_DUTY        1
`define PWMC_IRQ_PERIOD      0

`define PWMC_RST_CTRL        8'h00
`define PWMC_RST_VALUE       16'h0000
`define PWMC_PRESCALE_MAX    3'h7

`endif

// ==== src/pwmc_pkg.sv ====
// Types shared by the PWM channel control block
package pwmc_pkg;
	typedef enum logic [1:0] {
		PWMC_STANDARD,
		PWMC_SET_ON_MATCH,
		PWMC_TOGGLE_ON_MATCH,
		PWMC_CENTER_ALIGNED
	} pwmc_mode_e;

	typedef enum logic [1:0] {
		PWMC_SRC_SYSTEM,
		PWMC_SRC_FAST_OSC,
		PWMC_SRC_SLOW_OSC,
		PWMC_SRC_RESERVED
	} pwmc_clk_src_e;

	typedef enum logic [1:0] {
		PWMC_RUN_INDEPENDENT,
		PWMC_RUN_SLAVE_SYNC,
		PWMC_RUN_ONE_SHOT,
		PWMC_RUN_CONT_RESET
	} pwmc_slave_style_e;
endpackage

// ==== src/pwmc_top.sv ====
// One 16-bit PWM channel with its APB register file
// Functional notes
// - Waveform keeps running in sleep when an internal oscillator clocks it.
// - Four match flags: phase, duty, period, offset; set on match rising edge.
// - Control bit 7 enables the channel; resets to zero.
// - Control bit 6 connects the waveform to the output pin.
// - Control bit 5 shows the current output state, hardware driven.
// - Control bit 4 set makes the active output level low.
// - Control bits 3-2 pick standard, set, toggle or center-aligned waveform.
// - Enable bits 3..0 gate offset, phase, duty, period requests.
// - Flag bits 3..0 record offset, phase, duty, period events; writable.
// - Channel disabled holds all four flags cleared.
// - Prescale field divides selected clock by two to the power of it.
// - Clock source: 00 system, 01 fast osc, 10 slow osc, 11 reserved.
// - Armed reload loads buffers at period end, or at the first period end after a trigger if chosen.
// - Completed reload clears the armed bit; software may also clear it.
// - Trigger-load bit enables triggered reload; else trigger field ignored.
// - Reload trigger field picks channel 1..3 load event; 00 and own reserved.
// - Slave styles: independent, sync start, one-shot, continuous with reset.
// - Center mode: offset match on down-count match when bit 4 set.
// - Offset trigger field picks channel 1..3 offset match; 00, own reserved.
// - Phase, duty, period compares are 16-bit high/low byte pairs.
// - Compare pairs and direction bit act only after an armed reload.
// - Arming in the same cycle as a period match waits a period.
// - Center mode counts up to period then down to zero.
`timescale 1ns/100ps
`include "pwmc_defs.svh"

module pwmc_top
	import pwmc_pkg::*;
#(
	parameter int        CNT_W      = 16,
	parameter logic[1:0] CHANNEL_ID = 2'h1
) (
	input  wire logic                    sys_clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic                    psel_i,
	input  wire logic                    penable_i,
	input  wire logic                    pwrite_i,
	input  wire logic [`PWMC_ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]             pwdata_i,
	output logic      [31:0]             prdata_o,
	output logic                         pready_o,
	output logic                         pslverr_o,
	input  wire logic                    sleep_i,
	input  wire logic                    fast_osc_tick_i,
	input  wire logic                    slow_osc_tick_i,
	input  wire logic [3:0]              peer_offset_match_i,
	input  wire logic [3:0]              peer_reload_done_i,
	output logic                         offset_match_event_o,
	output logic                         reload_done_trigger_o,
	output logic                         pwm_pin_o,
	output logic                         pwm_pin_en_o,
	output logic                         irq_o
);
	logic [7:0]       channel_control;
	logic [3:0]       irq_enable_mask;
	logic [3:0]       irq_event_flags;
	logic [7:0]       clock_select;
	logic [7:0]       reload_control;
	logic [7:0]       slave_sync_control;
	logic [CNT_W-1:0] angle_compare_value;
	logic [CNT_W-1:0] duty_compare_value;
	logic [CNT_W-1:0] period_compare_value;
	logic [CNT_W-1:0] offset_compare_value;
	logic [CNT_W-1:0] angle_op;
	logic [CNT_W-1:0] duty_op;
	logic [CNT_W-1:0] period_op;
	logic [CNT_W-1:0] offset_op;
	logic             center_dir_op;
	logic [CNT_W-1:0] channel_counter;
	logic             count_down;
	logic [6:0]       prescale_count;
	logic             run_active;
	logic             out_state;
	logic             trigger_seen;
	logic [3:0]       match_prev;
	logic             bus_write;
	logic             bus_read;
	logic             addr_known;
	logic             enabled;
	logic             center_mode;
	logic             source_tick;
	logic [6:0]       prescale_mask;
	logic             tick;
	logic             counting;
	logic             period_event;
	logic             peer_offset;
	logic             peer_reload;
	logic             load_now;
	logic [CNT_W-1:0] center_rise;
	logic [3:0]       match_level;
	logic [3:0]       match_rise;
	pwmc_mode_e        mode;
	pwmc_clk_src_e     clk_src;
	pwmc_slave_style_e slave_run_style;

	assign enabled     = channel_control[`PWMC_CON_EN];
	assign mode        = pwmc_mode_e'(
		channel_control[`PWMC_CON_MODE_HI:`PWMC_CON_MODE_LO]);
	assign center_mode = (mode == PWMC_CENTER_ALIGNED);
	assign clk_src     = pwmc_clk_src_e'(
		clock_select[`PWMC_CLK_CS_HI:`PWMC_CLK_CS_LO]);
	assign slave_run_style = pwmc_slave_style_e'(
		slave_sync_control[`PWMC_OF_STYLE_HI:`PWMC_OF_STYLE_LO]);

	// APB: zero wait states, every access completes in its first access cycle
	assign bus_write = psel_i & penable_i & pwrite_i;
	assign bus_read  = psel_i & penable_i & ~pwrite_i;
	assign pready_o  = 1'b1;

	always_comb begin
		addr_known = 1'b1;
		prdata_o   = 32'h0000_0000;
		unique case (paddr_i)
			`PWMC_OFS_CON:    prdata_o[7:0] = channel_control;
			`PWMC_OFS_INTE:   prdata_o[3:0] = irq_enable_mask;
			`PWMC_OFS_INTF:   prdata_o[3:0] = irq_event_flags;
			`PWMC_OFS_CLKCON: prdata_o[7:0] = clock_select;
			`PWMC_OFS_LDCON:  prdata_o[7:0] = reload_control;
			`PWMC_OFS_OFCON:  prdata_o[7:0] = slave_sync_control;
			`PWMC_OFS_PHH:    prdata_o[7:0] = angle_compare_value[15:8];
			`PWMC_OFS_PHL:    prdata_o[7:0] = angle_compare_value[7:0];
			`PWMC_OFS_DCH:    prdata_o[7:0] = duty_compare_value[15:8];
			`PWMC_OFS_DCL:    prdata_o[7:0] = duty_compare_value[7:0];
			`PWMC_OFS_PRH:    prdata_o[7:0] = period_compare_value[15:8];
			`PWMC_OFS_PRL:    prdata_o[7:0] = period_compare_value[7:0];
			`PWMC_OFS_OFH:    prdata_o[7:0] = offset_compare_value[15:8];
			`PWMC_OFS_OFL:    prdata_o[7:0] = offset_compare_value[7:0];
			`PWMC_OFS_TMRH:   prdata_o[7:0] = channel_counter[15:8];
			`PWMC_OFS_TMRL:   prdata_o[7:0] = channel_counter[7:0];
			default:          addr_known = 1'b0;
		endcase
		if (!bus_read) begin
			prdata_o = 32'h0000_0000;
		end
	end

	assign pslverr_o = psel_i & penable_i & ~addr_known;

	// Control: output bit is hardware owned, software writes to it are dropped
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			channel_control <= `PWMC_RST_CTRL;
		end else begin
			if (bus_write && paddr_i == `PWMC_OFS_CON) begin
				channel_control[7:6] <= pwdata_i[7:6];
				channel_control[4:2] <= pwdata_i[4:2];
			end
			channel_control[`PWMC_CON_OUT] <= out_state;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			irq_enable_mask    <= 4'h0;
			clock_select       <= `PWMC_RST_CTRL;
			slave_sync_control <= `PWMC_RST_CTRL;
		end else if (bus_write) begin
			if (paddr_i == `PWMC_OFS_INTE) begin
				irq_enable_mask <= pwdata_i[3:0];
			end
			if (paddr_i == `PWMC_OFS_CLKCON) begin
				clock_select <= pwdata_i[7:0] & 8'h73;
			end
			if (paddr_i == `PWMC_OFS_OFCON) begin
				slave_sync_control <= pwdata_i[7:0] & 8'h73;
			end
		end
	end

	// Compare pairs reset to a known zero; software must load them anyway
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			angle_compare_value  <= `PWMC_RST_VALUE;
			duty_compare_value   <= `PWMC_RST_VALUE;
			period_compare_value <= `PWMC_RST_VALUE;
			offset_compare_value <= `PWMC_RST_VALUE;
		end else if (bus_write) begin
			unique case (paddr_i)
				`PWMC_OFS_PHH: angle_compare_value[15:8]  <= pwdata_i[7:0];
				`PWMC_OFS_PHL: angle_compare_value[7:0]   <= pwdata_i[7:0];
				`PWMC_OFS_DCH: duty_compare_value[15:8]   <= pwdata_i[7:0];
				`PWMC_OFS_DCL: duty_compare_value[7:0]    <= pwdata_i[7:0];
				`PWMC_OFS_PRH: period_compare_value[15:8] <= pwdata_i[7:0];
				`PWMC_OFS_PRL: period_compare_value[7:0]  <= pwdata_i[7:0];
				`PWMC_OFS_OFH: offset_compare_value[15:8] <= pwdata_i[7:0];
				`PWMC_OFS_OFL: offset_compare_value[7:0]  <= pwdata_i[7:0];
				default: ;
			endcase
		end
	end

	// Clock source and prescaler
	always_comb begin
		unique case (clk_src)
			PWMC_SRC_SYSTEM:   source_tick = ~sleep_i;
			PWMC_SRC_FAST_OSC: source_tick = fast_osc_tick_i;
			PWMC_SRC_SLOW_OSC: source_tick = slow_osc_tick_i;
			PWMC_SRC_RESERVED: source_tick = 1'b0;
		endcase
	end

	assign prescale_mask = 7'((8'h01 <<
		clock_select[`PWMC_CLK_PS_HI:`PWMC_CLK_PS_LO]) - 8'h01);
	// Compare with >= so a smaller prescale takes hold at once, no wrap stall
	assign tick = enabled & source_tick & (prescale_count >= prescale_mask);

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || !enabled) begin
			prescale_count <= 7'h00;
		end else if (source_tick) begin
			prescale_count <= (prescale_count >= prescale_mask) ? 7'h00 :
				prescale_count + 7'h01;
		end
	end

	// Slave start/reset and reload trigger sources; 00 and own channel code never fire
	assign peer_offset = peer_offset_match_i[
		slave_sync_control[`PWMC_OF_SRC_HI:`PWMC_OF_SRC_LO]] &
		(slave_sync_control[`PWMC_OF_SRC_HI:`PWMC_OF_SRC_LO] != 2'h0) &
		(slave_sync_control[`PWMC_OF_SRC_HI:`PWMC_OF_SRC_LO] !=
		CHANNEL_ID);
	assign peer_reload = peer_reload_done_i[
		reload_control[`PWMC_LD_SRC_HI:`PWMC_LD_SRC_LO]] &
		(reload_control[`PWMC_LD_SRC_HI:`PWMC_LD_SRC_LO] != 2'h0) &
		(reload_control[`PWMC_LD_SRC_HI:`PWMC_LD_SRC_LO] !=
		CHANNEL_ID);

	assign counting = tick & run_active;
	assign period_event = counting & (center_mode ?
		(count_down && channel_counter == {CNT_W{1'b0}}) :
		(channel_counter == period_op));

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || !enabled) begin
			run_active <= 1'b0;
		end else begin
			unique case (slave_run_style)
				PWMC_RUN_INDEPENDENT: run_active <= 1'b1;
				PWMC_RUN_ONE_SHOT: begin
					if (period_event) begin
						run_active <= 1'b0;
					end else if (peer_offset) begin
						run_active <= 1'b1;
					end
				end
				default: begin
					if (peer_offset) begin
						run_active <= 1'b1;
					end
				end
			endcase
		end
	end

	// Timer; center mode climbs to the period then falls back to zero
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || !enabled) begin
			channel_counter <= `PWMC_RST_VALUE;
			count_down      <= 1'b0;
		end else if (run_active && peer_offset &&
				slave_run_style == PWMC_RUN_CONT_RESET) begin
			channel_counter <= CNT_W'(1);
			count_down      <= 1'b0;
		end else if (counting) begin
			if (center_mode) begin
				// Both ends are held one tick, so a cycle is 2*(period+1)
				if (period_event) begin
					count_down <= 1'b0;
				end else if (!count_down &&
						channel_counter >= period_op) begin
					count_down <= 1'b1;
				end else if (count_down) begin
					channel_counter <= channel_counter - CNT_W'(1);
				end else begin
					channel_counter <= channel_counter + CNT_W'(1);
				end
			end else if (period_event) begin
				channel_counter <= `PWMC_RST_VALUE;
			end else begin
				channel_counter <= channel_counter + CNT_W'(1);
			end
		end
	end

	// Match levels; held only while the counter actually runs
	assign center_rise = period_op - duty_op;

	always_comb begin
		match_level = 4'h0;
		if (enabled && run_active) begin
			match_level[`PWMC_IRQ_ANGLE]  = (channel_counter == angle_op);
			match_level[`PWMC_IRQ_DUTY]   = (channel_counter == duty_op);
			match_level[`PWMC_IRQ_PERIOD] = (channel_counter == period_op);
			match_level[`PWMC_IRQ_OFFSET] = (channel_counter == offset_op) &
				(!center_mode || (count_down == center_dir_op));
		end
	end

	assign match_rise = match_level & ~match_prev;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			match_prev           <= 4'h0;
			offset_match_event_o <= 1'b0;
		end else begin
			match_prev           <= match_level;
			offset_match_event_o <= match_rise[`PWMC_IRQ_OFFSET];
		end
	end

	// Waveform state
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || !enabled) begin
			out_state <= 1'b0;
		end else if (counting) begin
			unique case (mode)
				PWMC_STANDARD: begin
					if (channel_counter == duty_op) begin
						out_state <= 1'b0;
					end else if (channel_counter == angle_op) begin
						out_state <= 1'b1;
					end
				end
				PWMC_SET_ON_MATCH: begin
					if (channel_counter == angle_op) begin
						out_state <= 1'b1;
					end
				end
				PWMC_TOGGLE_ON_MATCH: begin
					if (channel_counter == angle_op) begin
						out_state <= ~out_state;
					end
				end
				PWMC_CENTER_ALIGNED: begin
					if (!count_down && channel_counter == center_rise) begin
						out_state <= 1'b1;
					end else if (count_down &&
							channel_counter == center_rise + CNT_W'(1)) begin
						out_state <= 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			pwm_pin_o    <= 1'b0;
			pwm_pin_en_o <= 1'b0;
		end else begin
			pwm_pin_en_o <= channel_control[`PWMC_CON_OE];
			pwm_pin_o    <= channel_control[`PWMC_CON_OE] &
				(out_state ^ channel_control[`PWMC_CON_POL]);
		end
	end

	// Flags: a hardware set in the same cycle as a software write wins
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || !enabled) begin
			irq_event_flags <= 4'h0;
		end else begin
			if (bus_write && paddr_i == `PWMC_OFS_INTF) begin
				irq_event_flags <= pwdata_i[3:0] | match_rise;
			end else begin
				irq_event_flags <= irq_event_flags | match_rise;
			end
		end
	end

	assign irq_o = |(irq_event_flags & irq_enable_mask);

	// Reload. A disabled channel loads as soon as it is armed.
	// An arm written in a period-match cycle is not yet visible, so it waits.
	assign load_now = reload_control[`PWMC_LD_ARMED] & (~enabled |
		(period_event & (~reload_control[`PWMC_LD_TRIG] |
		trigger_seen)));

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			reload_control <= `PWMC_RST_CTRL;
		end else if (bus_write && paddr_i == `PWMC_OFS_LDCON) begin
			reload_control <= pwdata_i[7:0] & 8'hC3;
		end else if (load_now) begin
			reload_control[`PWMC_LD_ARMED] <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || !reload_control[`PWMC_LD_ARMED] || load_now) begin
			trigger_seen <= 1'b0;
		end else if (reload_control[`PWMC_LD_TRIG] && peer_reload) begin
			trigger_seen <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			angle_op              <= `PWMC_RST_VALUE;
			duty_op               <= `PWMC_RST_VALUE;
			period_op             <= `PWMC_RST_VALUE;
			offset_op             <= `PWMC_RST_VALUE;
			center_dir_op         <= 1'b0;
			reload_done_trigger_o <= 1'b0;
		end else begin
			reload_done_trigger_o <= load_now;
			if (load_now) begin
				angle_op      <= angle_compare_value;
				duty_op       <= duty_compare_value;
				period_op     <= period_compare_value;
				offset_op     <= offset_compare_value;
				center_dir_op <= slave_sync_control[`PWMC_OF_DIR];
			end
		end
	end
endmodule
